// >>> pfm_pkg.sv
package pfm_pkg;
   localparam int PFM_NPINS = 3;
   localparam int PFM_PIN_ZERO = 0;
   localparam int PFM_PIN_ONE = 1;
   localparam int PFM_PIN_TWO = 2;
   // reset values: all port mode, all inputs, no pull-ups
   localparam logic [2:0] PFM_MODE_RST = 3'h0;
   localparam logic [2:0] PFM_DIR_RST = 3'h7;
   localparam logic [2:0] PFM_PU_RST = 3'h0;
   localparam logic [2:0] PFM_OUT_RST = 3'h0;
   localparam logic [2:0] PFM_OE_RST = 3'h0;
   localparam logic [1:0] PFM_ROUTE_RST = 2'h0;
   // input_route_select bits
   localparam int PFM_ROUTE_TIMER_H1_WAVE_OUT = 0;
   localparam int PFM_ROUTE_TIMER51_COUNT_IN = 1;
   typedef enum logic [1:0] {
      PFM_EDGE_NONE = 2'h0,
      PFM_EDGE_RISE = 2'h1,
      PFM_EDGE_FALL = 2'h2,
      PFM_EDGE_BOTH = 2'h3
   } pfm_edge_t;
endpackage : pfm_pkg

// >>> pfm_edge_det.sv
`timescale 1ns/1ps
module pfm_edge_det
   import pfm_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // pin side
   input wire logic i_pin,
   input wire logic i_enable,
   input wire logic [1:0] i_edge_sel,
   // outputs
   output logic o_level,
   output logic o_event
);
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic level_q;
   logic level_d;
   logic event_q;
   logic event_d;
   logic rise;
   logic fall;

   always_comb begin
      sync_d = {sync_q[1:0], i_pin};
      level_d = level_q;
      rise = 1'b0;
      fall = 1'b0;
      // change counts once second and third stages agree
      if (sync_q[2] == sync_q[1]) begin
         level_d = sync_q[2];
         rise = sync_q[2] & ~level_q;
         fall = ~sync_q[2] & level_q;
      end
      case (pfm_edge_t'(i_edge_sel))
         PFM_EDGE_RISE: event_d = i_enable & rise;
         PFM_EDGE_FALL: event_d = i_enable & fall;
         PFM_EDGE_BOTH: event_d = i_enable & (rise | fall);
         default: event_d = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync_q <= 3'h0;
         level_q <= 1'b0;
         event_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
         level_q <= level_d;
         event_q <= event_d;
      end
   end

   assign o_level = level_q;
   assign o_event = event_q;
endmodule : pfm_edge_det

// >>> pfm_port0_mux.sv
`timescale 1ns/1ps
module pfm_port0_mux
   import pfm_pkg::*;
#(
   parameter int NPINS = PFM_NPINS
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // software configuration
   input wire logic [NPINS-1:0] i_control_mode,
   input wire logic [NPINS-1:0] i_port_direction_reg,
   input wire logic [NPINS-1:0] i_pullup_select_reg,
   input wire logic [NPINS-1:0] i_port_latch,
   input wire logic [1:0] i_input_route_select,
   input wire logic [1:0] i_irq_zero_edge_sel,
   input wire logic [1:0] i_irq_five_edge_sel,
   // board pins
   input wire logic [NPINS-1:0] i_pin,
   output logic [NPINS-1:0] o_pin,
   output logic [NPINS-1:0] o_pin_oe,
   output logic [NPINS-1:0] o_pin_pullup,
   // peripheral outputs toward pins
   input wire logic i_timer00_wave_out,
   input wire logic i_timer_h1_wave_out,
   // peripheral inputs from pins
   output logic [NPINS-1:0] o_port_read,
   output logic o_timer00_clock_capture_in,
   output logic o_timer00_capture_in,
   output logic o_timer51_count_in,
   output logic o_ext_irq_line_zero,
   output logic o_ext_irq_line_five,
   output logic o_serial_slave_select_n
);
   logic [NPINS-1:0] mode_q;
   logic [NPINS-1:0] mode_d;
   logic [NPINS-1:0] dir_d;
   logic [NPINS-1:0] pu_q;
   logic [NPINS-1:0] pu_d;
   logic [NPINS-1:0] out_q;
   logic [NPINS-1:0] out_d;
   logic [NPINS-1:0] oe_q;
   logic [NPINS-1:0] oe_d;
   logic [1:0] route_q;
   logic [1:0] route_d;
   logic [NPINS-1:0] level;
   logic [NPINS-1:0] ctl_out_fn;
   logic [NPINS-1:0] ctl_out_val;
   logic [NPINS-1:0] irq_evt;
   logic [NPINS-1:0] irq_en;
   logic [1:0] irq_sel [NPINS];

   // per-pin three-stage sampler; only pins zero and two carry interrupts
   assign irq_sel[PFM_PIN_ZERO] = i_irq_zero_edge_sel;
   assign irq_sel[PFM_PIN_ONE] = PFM_EDGE_NONE;
   assign irq_sel[PFM_PIN_TWO] = i_irq_five_edge_sel;
   assign irq_en[PFM_PIN_ZERO] = mode_q[PFM_PIN_ZERO];
   assign irq_en[PFM_PIN_ONE] = 1'b0;
   assign irq_en[PFM_PIN_TWO] = mode_q[PFM_PIN_TWO];

   genvar g;
   generate
      for (g = 0; g < NPINS; g++) begin : g_pin
         pfm_edge_det u_det (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_pin(i_pin[g]),
            .i_enable(irq_en[g]),
            .i_edge_sel(irq_sel[g]),
            .o_level(level[g]),
            .o_event(irq_evt[g])
         );
      end
   endgenerate

   always_comb begin
      // which pins carry a peripheral output
      ctl_out_fn = '0;
      ctl_out_val = '0;
      // timer 00 wave on pin one
      // direction bit still rules pin one, so the board can drive a capture trigger
      ctl_out_fn[PFM_PIN_ONE] = ~i_port_direction_reg[PFM_PIN_ONE];
      ctl_out_val[PFM_PIN_ONE] = i_timer00_wave_out;
      // timer H1 wave only when routed to pin zero
      // unregistered route bit keeps the enable in step with the mode bit
      if (i_input_route_select[PFM_ROUTE_TIMER_H1_WAVE_OUT]) begin
         ctl_out_fn[PFM_PIN_ZERO] = 1'b1;
         ctl_out_val[PFM_PIN_ZERO] = i_timer_h1_wave_out;
      end
   end

   // configuration group
   always_comb begin
      mode_d = i_control_mode;
      dir_d = i_port_direction_reg;
      // pull-up only meaningful on an input in port mode
      pu_d = i_pullup_select_reg & ~mode_d & dir_d;
      route_d = i_input_route_select;
   end

   // reset leaves every pin a port-mode input
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mode_q <= PFM_MODE_RST;
         pu_q <= PFM_PU_RST;
         route_q <= PFM_ROUTE_RST;
      end else begin
         mode_q <= mode_d;
         pu_q <= pu_d;
         route_q <= route_d;
      end
   end

   // pin driver group
   always_comb begin
      oe_d = '0;
      out_d = '0;
      for (int i = 0; i < NPINS; i++) begin
         if (mode_d[i]) begin
            oe_d[i] = ctl_out_fn[i];
            out_d[i] = ctl_out_val[i];
         end else begin
            oe_d[i] = ~dir_d[i];
            out_d[i] = i_port_latch[i];
         end
      end
   end

   // no pin driven out of reset
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         out_q <= PFM_OUT_RST;
         oe_q <= PFM_OE_RST;
      end else begin
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign o_pin = out_q;
   assign o_pin_oe = oe_q;
   assign o_pin_pullup = pu_q;
   assign o_port_read = level;
   // pin zero gives timer 00 count clock and both capture triggers
   assign o_timer00_clock_capture_in = mode_q[PFM_PIN_ZERO] & level[PFM_PIN_ZERO];
   // pin one triggers the first capture register only
   assign o_timer00_capture_in = mode_q[PFM_PIN_ONE] & level[PFM_PIN_ONE];
   // timer 51 count clock, only when routed
   assign o_timer51_count_in = mode_q[PFM_PIN_ZERO] & route_q[PFM_ROUTE_TIMER51_COUNT_IN]
      & level[PFM_PIN_ZERO];
   assign o_ext_irq_line_zero = irq_evt[PFM_PIN_ZERO];
   assign o_ext_irq_line_five = irq_evt[PFM_PIN_TWO];
   // select held inactive (high) unless in control mode
   assign o_serial_slave_select_n = ~mode_q[PFM_PIN_TWO] | level[PFM_PIN_TWO];
endmodule : pfm_port0_mux

// >>> pfm_board_model.sv
`timescale 1ns/1ps
module pfm_board_model (
   // clock and board drive
   input wire logic i_clk,
   input wire logic [2:0] i_drive_en,
   input wire logic [2:0] i_drive,
   // device pin outputs
   input wire logic [2:0] i_pin,
   input wire logic [2:0] i_pin_oe,
   input wire logic [2:0] i_pin_pullup,
   output logic [2:0] o_level
);
   logic float_q = 1'b0;
   always_ff @(posedge i_clk) float_q <= ~float_q;
   // undriven pin wanders unless pulled up, so a stale level never passes
   assign o_level = (i_pin_oe & i_pin) | (~i_pin_oe & i_drive_en & i_drive)
      | (~i_pin_oe & ~i_drive_en & (i_pin_pullup | {3{float_q}}));
endmodule : pfm_board_model

// >>> pfm_port0_mux_assertions.sv
`timescale 1ns/1ps
module pfm_port0_mux_assertions
   import pfm_pkg::*;
#(parameter int NPINS = PFM_NPINS) (
   // watched ports
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [NPINS-1:0] i_control_mode,
   input wire logic [NPINS-1:0] i_port_direction_reg,
   input wire logic [NPINS-1:0] i_pullup_select_reg,
   input wire logic [NPINS-1:0] i_port_latch,
   input wire logic [1:0] i_input_route_select,
   input wire logic [1:0] i_irq_zero_edge_sel,
   input wire logic i_timer_h1_wave_out,
   input wire logic [NPINS-1:0] o_pin,
   input wire logic [NPINS-1:0] o_pin_oe,
   input wire logic [NPINS-1:0] o_pin_pullup,
   input wire logic [NPINS-1:0] o_port_read,
   input wire logic o_timer51_count_in,
   input wire logic o_ext_irq_line_zero,
   input wire logic o_serial_slave_select_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   wire logic [NPINS-1:0] pm = ~i_control_mode;
   sequence s_up0;
      $rose(o_port_read[0]) && i_control_mode[0] && i_irq_zero_edge_sel == PFM_EDGE_RISE;
   endsequence
   chk_port_dir: assert property ($past(i_reset_n) |->
      (o_pin_oe & $past(pm)) == $past(pm & ~i_port_direction_reg)) else $error("oe wrong");
   chk_port_data: assert property ($past(i_reset_n) |->
      (o_pin & o_pin_oe & $past(pm)) == $past(pm & ~i_port_direction_reg & i_port_latch))
      else $error("pin data wrong");
   chk_pullup_sel: assert property ($past(i_reset_n) |->
      o_pin_pullup == $past(pm & i_port_direction_reg & i_pullup_select_reg))
      else $error("pull-up wrong");
   chk_h1_route: assert property ($past(i_reset_n && i_control_mode[0] &&
      i_input_route_select[0]) |-> o_pin_oe[0] && o_pin[0] == $past(i_timer_h1_wave_out))
      else $error("timer h1 not on pin");
   chk_t51_gate: assert property ($past(i_reset_n) && !i_input_route_select[1] &&
      !$past(i_input_route_select[1]) |-> !o_timer51_count_in) else $error("t51 leak");
   chk_ssel_idle: assert property ($past(i_reset_n) && !i_control_mode[2] &&
      !$past(i_control_mode[2]) |-> o_serial_slave_select_n) else $error("select leak");
   chk_irq_gate: assert property (o_ext_irq_line_zero |-> $past(i_control_mode[0], 2) &&
      $past(i_irq_zero_edge_sel) != PFM_EDGE_NONE) else $error("irq not gated");
   chk_rise_pulse: assert property (s_up0 |-> ##[0:2] o_ext_irq_line_zero)
      else $error("rise pulse missing");
endmodule : pfm_port0_mux_assertions
bind pfm_port0_mux pfm_port0_mux_assertions #(.NPINS(NPINS)) i_chk (.i_clk, .i_reset_n,
   .i_control_mode, .i_port_direction_reg, .i_pullup_select_reg, .i_port_latch,
   .i_input_route_select, .i_irq_zero_edge_sel, .i_timer_h1_wave_out, .o_pin, .o_pin_oe,
   .o_pin_pullup, .o_port_read, .o_timer51_count_in, .o_ext_irq_line_zero,
   .o_serial_slave_select_n);

// >>> pfm_port0_mux_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
   $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module pfm_port0_mux_bench;
   import pfm_pkg::*;
   logic i_clk = 1'b0, i_reset_n = 1'b0, t00 = 1'b1, th1 = 1'b0;
   logic [2:0] md = 3'h0, dir = 3'h7, pu = 3'h0, lat = 3'h0, den = 3'h0, drv = 3'h0, lvl;
   logic [1:0] rt = 2'h0, s0 = 2'h0, s5 = 2'h0;
   logic [2:0] pin, oe, pull, rd;
   logic ck, cap, c51, q0, q5, ss_n;
   int fails = 0, checked = 0, cycles = 0, n0 = 0, n5 = 0;
   pfm_port0_mux i_pfm_port0_mux (.i_clk, .i_reset_n, .i_control_mode(md),
      .i_port_direction_reg(dir), .i_pullup_select_reg(pu), .i_port_latch(lat),
      .i_input_route_select(rt), .i_irq_zero_edge_sel(s0), .i_irq_five_edge_sel(s5),
      .i_pin(lvl), .o_pin(pin), .o_pin_oe(oe), .o_pin_pullup(pull),
      .i_timer00_wave_out(t00), .i_timer_h1_wave_out(th1), .o_port_read(rd),
      .o_timer00_clock_capture_in(ck), .o_timer00_capture_in(cap), .o_timer51_count_in(c51),
      .o_ext_irq_line_zero(q0), .o_ext_irq_line_five(q5), .o_serial_slave_select_n(ss_n));
   pfm_board_model i_pfm_board_model (.i_clk, .i_drive_en(den), .i_drive(drv), .i_pin(pin),
      .i_pin_oe(oe), .i_pin_pullup(pull), .o_level(lvl));
   initial forever #50 i_clk = ~i_clk;
   // hang guard: whole run needs well under 400 cycles
   always @(posedge i_clk) begin
      cycles++;
      n0 += (q0 === 1'b1);
      n5 += (q5 === 1'b1);
      if (cycles == 2000) begin fails++; conclude(); end
   end
   task automatic cyc(input int n); repeat (n) @(negedge i_clk); endtask : cyc
   task automatic conclude;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic t_reset;
      cyc(2);
      `CHK({oe, pull, ss_n}, 7'h01)
   endtask : t_reset
   task automatic t_port;
      dir = 3'h2; lat = 3'h5; pu = 3'h7; cyc(6);
      `CHK({oe, pin & oe, pull}, 9'h16a)
      `CHK(rd, 3'h7)
      pu = 3'h5; den = 3'h2; cyc(6);
      `CHK({rd, pull}, 6'h28)
   endtask : t_port
   task automatic t_ctrl;
      md = 3'h7; dir = 3'h7; rt = 2'h1; th1 = 1'b1; den = 3'h6; drv = 3'h2; cyc(6);
      `CHK({oe[0], pin[0], pull}, 5'h18)
      `CHK({cap, ss_n, c51}, 3'h4)
      rt = 2'h2; t00 = 1'b0; den = 3'h7; drv = 3'h5; dir = 3'h5; cyc(6);
      `CHK({oe[0], ck, c51, cap, ss_n}, 5'h0d)
      `CHK({oe[1], pin[1]}, 2'h2)
      t00 = 1'b1; cyc(6);
      `CHK({oe[1], pin[1], cap}, 3'h7)
      md = 3'h0; cyc(6);
      `CHK({ck, c51, cap, ss_n}, 4'h1)
   endtask : t_ctrl
   task automatic t_irq;
      for (int s = 0; s < 4; s++) begin
         md = 3'h5; rt = 2'h0; s0 = s[1:0]; s5 = s[1:0]; drv = 3'h0; cyc(8);
         n0 = 0; n5 = 0; drv = 3'h5; cyc(8); drv = 3'h0; cyc(8);
         `CHK({n0[1:0], n5[1:0]}, (s == 3) ? 4'ha : (s != 0) ? 4'h5 : 4'h0)
      end
   endtask : t_irq
   initial begin
      cyc(8);
      i_reset_n = 1'b1;
      t_reset();
      t_port();
      t_ctrl();
      t_irq();
      conclude();
   end
endmodule : pfm_port0_mux_bench
